//--- src/dmia_defs.svh
// Address map and decode constants of the data memory addressing block
`ifndef DMIA_DEFS_SVH
`define DMIA_DEFS_SVH

`define DMIA_OFF_INDIRECT_ACCESS_ZERO 8'h00
`define DMIA_OFF_PTR0 8'h01
`define DMIA_OFF_INDIRECT_ACCESS_ONE 8'h02
`define DMIA_OFF_P1L 8'h03
`define DMIA_OFF_P1S 8'h04
`define DMIA_OFF_INDIRECT_ACCESS_TWO 8'h0c
`define DMIA_OFF_P2L 8'h0d
`define DMIA_OFF_P2S 8'h0e
`define DMIA_GP_BASE 8'h80
`define DMIA_SECTORS 8'h08
`define DMIA_ZERO 8'h00
`define DMIA_ONE_BIT 8'h01
`define DMIA_PTR_RESET 8'h00
`define DMIA_RAM_DEPTH 1024

`endif

//--- src/dmia_gpram.sv
// General purpose data memory, all sectors, upper half of each
`timescale 1ns/1ps
`default_nettype none
`include "dmia_defs.svh"
module dmia_gpram (
  input wire logic clock,
  dmia_ram_if.mem ram
);
  logic [7:0] mem [`DMIA_RAM_DEPTH];

  // Asynchronous read so bit set/clear completes in one cycle
  assign ram.rdata = mem[ram.addr];

  always_ff @(posedge clock) begin
    if (ram.we) begin
      mem[ram.addr] <= ram.wdata;
    end
  end
endmodule
`default_nettype wire

//--- src/dmia_pkg.sv
// Types shared by the data memory addressing block
package dmia_pkg;
  typedef enum logic [2:0] {
    DMIA_BIT_NONE = 3'b001,
    DMIA_BIT_SET = 3'b010,
    DMIA_BIT_CLR = 3'b100
  } dmia_bitop_t;

  typedef enum logic [3:0] {
    DMIA_TGT_NONE = 4'b0001,
    DMIA_TGT_PTR = 4'b0010,
    DMIA_TGT_SFR = 4'b0100,
    DMIA_TGT_RAM = 4'b1000
  } dmia_tgt_t;
endpackage

//--- src/dmia_ram_if.sv
// Link between the address resolver and the general purpose RAM
`timescale 1ns/1ps
`default_nettype none
interface dmia_ram_if;
  logic [9:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

//--- src/dmia_top.sv
// Data memory address resolution with indirect access and memory pointers
//
// Function
// [RULE1] There is no data bank register; indirect sector choice comes only from a pointer high byte.
// [RULE2] Pair one and pair two take the sector from the high byte and the location from the low byte.
// [RULE3] Extended addresses have 11 bits, the upper part selects the sector, the low byte the location.
// [RULE4] Extended direct addresses reach every sector with no pointer setup.
// [RULE5] An access to an indirect location acts on the location its pointer addresses.
// [RULE6] Indirect location zero reaches sector 0 only; locations one and two reach any sector.
// [RULE7] Indirect locations hold nothing: read as 00H, writes change nothing of their own.
// [RULE8] The five pointer bytes are real storage, readable, writable and modifiable.
// [RULE9] Unused special locations read as 00H.
// [RULE10] Protected special locations ignore writes.
// [RULE11] General purpose memory supports read, write and single bit set and clear.
// [RULE12] Offsets 00H to 7FH decode to the special area, 80H to FFH to the general area.
// [RULE13] An indirect target in a missing sector or location reads 00H and ignores writes.
`timescale 1ns/1ps
`default_nettype none
`include "dmia_defs.svh"
module dmia_top
  import dmia_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ext,
  input wire logic [10:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire dmia_bitop_t req_bitop,
  input wire logic [2:0] req_bit,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [2:0] sfr_look_sector,
  output logic [6:0] sfr_look_offset,
  input wire logic sfr_hit,
  input wire logic sfr_ro,
  input wire logic [7:0] sfr_rdata,
  output logic sfr_we,
  output logic [2:0] sfr_sector,
  output logic [6:0] sfr_offset,
  output logic [7:0] sfr_wdata
);
  dmia_ram_if ram_link ();

  dmia_gpram u_ram (
    .clock(clock),
    .ram(ram_link.mem)
  );

  // ****************************************
  // Address resolution
  // ****************************************
  logic [7:0] sector0_pointer;
  logic [7:0] pointer_one_low;
  logic [7:0] pointer_one_sector;
  logic [7:0] pointer_two_low;
  logic [7:0] pointer_two_sector;
  logic [7:0] eff_sec;
  logic [7:0] eff_off;
  logic indirect;
  logic wr;
  dmia_tgt_t tgt;
  logic [7:0] old_val;
  logic [7:0] new_val;
  logic [7:0] bit_mask;

  function automatic logic is_iar(input logic [7:0] off);
    is_iar = (off == `DMIA_OFF_INDIRECT_ACCESS_ZERO) || (off == `DMIA_OFF_INDIRECT_ACCESS_ONE) || (off == `DMIA_OFF_INDIRECT_ACCESS_TWO);
  endfunction

  function automatic logic is_ptr(input logic [7:0] off);
    is_ptr = (off == `DMIA_OFF_PTR0) || (off == `DMIA_OFF_P1L) || (off == `DMIA_OFF_P1S) ||
             (off == `DMIA_OFF_P2L) || (off == `DMIA_OFF_P2S);
  endfunction

  always_comb begin
    indirect = 1'b0;
    eff_off = req_addr[7:0];
    eff_sec = `DMIA_ZERO;
    if (req_ext) begin
      eff_sec = 8'(req_addr[10:8]); // RULE3
    end
    if (eff_sec == `DMIA_ZERO) begin
      if (eff_off == `DMIA_OFF_INDIRECT_ACCESS_ZERO) begin
        indirect = 1'b1;
        eff_off = sector0_pointer; // RULE6
      end else if (eff_off == `DMIA_OFF_INDIRECT_ACCESS_ONE) begin
        indirect = 1'b1;
        eff_sec = pointer_one_sector; // RULE1
        eff_off = pointer_one_low; // RULE2
      end else if (eff_off == `DMIA_OFF_INDIRECT_ACCESS_TWO) begin
        indirect = 1'b1;
        eff_sec = pointer_two_sector; // RULE2
        eff_off = pointer_two_low; // RULE5
      end
    end
  end

  assign sfr_look_sector = eff_sec[2:0];
  assign sfr_look_offset = eff_off[6:0];

  always_comb begin
    if (!req_valid) begin
      tgt = DMIA_TGT_NONE;
    end else if (eff_sec >= `DMIA_SECTORS) begin
      tgt = DMIA_TGT_NONE; // RULE13
    end else if (eff_off >= `DMIA_GP_BASE) begin
      tgt = DMIA_TGT_RAM; // RULE12
    end else if (eff_sec == `DMIA_ZERO && is_iar(eff_off)) begin
      tgt = DMIA_TGT_NONE; // RULE7
    end else if (eff_sec == `DMIA_ZERO && is_ptr(eff_off)) begin
      tgt = DMIA_TGT_PTR; // RULE8
    end else if (sfr_hit) begin
      tgt = DMIA_TGT_SFR;
    end else begin
      tgt = DMIA_TGT_NONE; // RULE9
    end
  end

  always_comb begin
    old_val = `DMIA_ZERO;
    case (eff_off)
      `DMIA_OFF_PTR0: old_val = sector0_pointer;
      `DMIA_OFF_P1L: old_val = pointer_one_low;
      `DMIA_OFF_P1S: old_val = pointer_one_sector;
      `DMIA_OFF_P2L: old_val = pointer_two_low;
      `DMIA_OFF_P2S: old_val = pointer_two_sector;
      default: old_val = `DMIA_ZERO;
    endcase
    if (tgt == DMIA_TGT_RAM) begin
      old_val = ram_link.rdata;
    end else if (tgt == DMIA_TGT_SFR) begin
      old_val = sfr_rdata;
    end else if (tgt != DMIA_TGT_PTR) begin
      old_val = `DMIA_ZERO;
    end
  end

  // Bit operations are read-modify-write of the resolved location
  assign bit_mask = `DMIA_ONE_BIT << req_bit;
  assign wr = req_valid && (req_write || req_bitop != DMIA_BIT_NONE);

  always_comb begin
    case (req_bitop)
      DMIA_BIT_SET: new_val = old_val | bit_mask; // RULE11
      DMIA_BIT_CLR: new_val = old_val & ~bit_mask; // RULE11
      default: new_val = req_wdata;
    endcase
  end

  assign ram_link.addr = {eff_sec[2:0], eff_off[6:0]}; // RULE4
  assign ram_link.we = wr && (tgt == DMIA_TGT_RAM);
  assign ram_link.wdata = new_val;

  // ****************************************
  // Pointers, read return and special writes
  // ****************************************
  logic [7:0] next_sector0_pointer;
  logic [7:0] next_pointer_one_low;
  logic [7:0] next_pointer_one_sector;
  logic [7:0] next_pointer_two_low;
  logic [7:0] next_pointer_two_sector;
  logic next_rd_valid;
  logic [7:0] next_rd_data;
  logic next_sfr_we;
  logic [2:0] next_sfr_sector;
  logic [6:0] next_sfr_offset;
  logic [7:0] next_sfr_wdata;

  always_comb begin
    next_sector0_pointer = sector0_pointer;
    next_pointer_one_low = pointer_one_low;
    next_pointer_one_sector = pointer_one_sector;
    next_pointer_two_low = pointer_two_low;
    next_pointer_two_sector = pointer_two_sector;
    if (wr && tgt == DMIA_TGT_PTR) begin
      case (eff_off)
        `DMIA_OFF_PTR0: next_sector0_pointer = new_val; // RULE8
        `DMIA_OFF_P1L: next_pointer_one_low = new_val;
        `DMIA_OFF_P1S: next_pointer_one_sector = new_val;
        `DMIA_OFF_P2L: next_pointer_two_low = new_val;
        `DMIA_OFF_P2S: next_pointer_two_sector = new_val;
        default: next_sector0_pointer = sector0_pointer;
      endcase
    end
    next_rd_valid = req_valid && !wr;
    next_rd_data = next_rd_valid ? old_val : rd_data;
    // Protected locations never see a strobe
    next_sfr_we = wr && (tgt == DMIA_TGT_SFR) && !sfr_ro; // RULE10
    next_sfr_sector = (tgt == DMIA_TGT_SFR) ? eff_sec[2:0] : sfr_sector;
    next_sfr_offset = (tgt == DMIA_TGT_SFR) ? eff_off[6:0] : sfr_offset;
    next_sfr_wdata = (tgt == DMIA_TGT_SFR) ? new_val : sfr_wdata;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sector0_pointer <= `DMIA_PTR_RESET;
      pointer_one_low <= `DMIA_PTR_RESET;
      pointer_one_sector <= `DMIA_PTR_RESET;
      pointer_two_low <= `DMIA_PTR_RESET;
      pointer_two_sector <= `DMIA_PTR_RESET;
      rd_valid <= 1'b0;
      rd_data <= `DMIA_ZERO;
      sfr_we <= 1'b0;
      sfr_sector <= 3'h0;
      sfr_offset <= 7'h00;
      sfr_wdata <= `DMIA_ZERO;
    end else begin
      sector0_pointer <= next_sector0_pointer;
      pointer_one_low <= next_pointer_one_low;
      pointer_one_sector <= next_pointer_one_sector;
      pointer_two_low <= next_pointer_two_low;
      pointer_two_sector <= next_pointer_two_sector;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      sfr_we <= next_sfr_we;
      sfr_sector <= next_sfr_sector;
      sfr_offset <= next_sfr_offset;
      sfr_wdata <= next_sfr_wdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_indirect_access_zero_sector0;
    @(posedge clock) disable iff (!nrst)
      req_valid && !req_ext && req_addr[7:0] == `DMIA_OFF_INDIRECT_ACCESS_ZERO && sector0_pointer[7]
      |-> ram_link.addr == {3'h0, sector0_pointer[6:0]};
  endproperty
  a_indirect_access_zero_sector0: assert property (p_indirect_access_zero_sector0) else $error("pointer zero left sector 0"); // RULE6

  property p_pair_one;
    @(posedge clock) disable iff (!nrst)
      req_valid && !req_ext && req_addr[7:0] == `DMIA_OFF_INDIRECT_ACCESS_ONE &&
      pointer_one_sector < `DMIA_SECTORS && pointer_one_low[7]
      |-> ram_link.addr == {pointer_one_sector[2:0], pointer_one_low[6:0]};
  endproperty
  a_pair_one: assert property (p_pair_one) else $error("pair one address wrong"); // RULE2

  property p_ext_direct;
    @(posedge clock) disable iff (!nrst)
      req_valid && req_ext && req_addr[7]
      |-> tgt == DMIA_TGT_RAM && ram_link.addr == {req_addr[10:8], req_addr[6:0]};
  endproperty
  a_ext_direct: assert property (p_ext_direct) else $error("extended address wrong"); // RULE4

  property p_none_reads_zero;
    @(posedge clock) disable iff (!nrst)
      req_valid && !wr && tgt == DMIA_TGT_NONE |=> rd_valid && rd_data == `DMIA_ZERO;
  endproperty
  a_none_reads_zero: assert property (p_none_reads_zero) else $error("empty location not 00"); // RULE9

  property p_iar_self;
    @(posedge clock) disable iff (!nrst)
      req_valid && !req_ext && req_addr[7:0] == `DMIA_OFF_INDIRECT_ACCESS_ZERO && sector0_pointer == `DMIA_OFF_INDIRECT_ACCESS_TWO
      |-> !ram_link.we ##1 !sfr_we && $stable(sector0_pointer);
  endproperty
  a_iar_self: assert property (p_iar_self) else $error("indirect location stored data"); // RULE7

  property p_ptr_write;
    @(posedge clock) disable iff (!nrst)
      req_valid && req_write && req_bitop == DMIA_BIT_NONE && !req_ext &&
      req_addr[7:0] == `DMIA_OFF_P2S
      |=> pointer_two_sector == $past(req_wdata);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer not written"); // RULE8

  property p_ro_protect;
    @(posedge clock) disable iff (!nrst)
      wr && tgt == DMIA_TGT_SFR && sfr_ro |=> !sfr_we;
  endproperty
  a_ro_protect: assert property (p_ro_protect) else $error("protected location written"); // RULE10

  property p_bad_sector;
    @(posedge clock) disable iff (!nrst)
      req_valid && indirect && eff_sec >= `DMIA_SECTORS |-> !ram_link.we ##1 !sfr_we;
  endproperty
  a_bad_sector: assert property (p_bad_sector) else $error("missing sector written"); // RULE13

  property p_bit_set;
    @(posedge clock) disable iff (!nrst)
      req_valid && req_bitop == DMIA_BIT_SET && tgt == DMIA_TGT_RAM
      |-> ram_link.we && ram_link.wdata[req_bit] && (ram_link.wdata | bit_mask) == (old_val | bit_mask);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set lost"); // RULE11
endmodule
`default_nettype wire

//--- tb/dmia_sfr_model.sv
// Model of the special register file seen through the lookup port
`timescale 1ns/1ps
`default_nettype none
module dmia_sfr_model #(
  parameter logic [7:0] RO_VALUE = 8'h5a
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [2:0] look_sector,
  input wire logic [6:0] look_offset,
  output logic hit,
  output logic ro,
  output logic [7:0] rdata,
  input wire logic we,
  input wire logic [2:0] sector,
  input wire logic [6:0] offset,
  input wire logic [7:0] wdata
);
  logic [7:0] user_reg;
  always_comb begin
    hit = 1'b0;
    ro = 1'b0;
    // Junk on a miss so a leaked value shows up as nonzero
    rdata = 8'hc3;
    if (look_sector == 3'h0 && look_offset == 7'h0a) begin
      hit = 1'b1;
      ro = 1'b1;
      rdata = RO_VALUE;
    end else if (look_sector == 3'h1 && look_offset == 7'h05) begin
      hit = 1'b1;
      rdata = user_reg;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      user_reg <= 8'h00;
    end else if (we && sector == 3'h1 && offset == 7'h05) begin
      user_reg <= wdata;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench of the data memory addressing block
`timescale 1ns/1ps
`default_nettype none
module tb
  import dmia_pkg::*;
;
  typedef struct {logic w; logic e; logic [10:0] a; logic [7:0] d;
    dmia_bitop_t op; logic [2:0] b; logic [7:0] x;} dmia_row_t;
  logic clock, nrst, req_valid, req_write, req_ext, rd_valid, sfr_hit, sfr_ro, sfr_we;
  logic [10:0] req_addr;
  logic [7:0] req_wdata, rd_data, sfr_rdata, sfr_wdata;
  dmia_bitop_t req_bitop;
  logic [2:0] req_bit, sfr_look_sector, sfr_sector;
  logic [6:0] sfr_look_offset, sfr_offset;
  int error_cnt, cmp_count;
  dmia_row_t rows[$];
  logic [10:0] ptrs[5] = '{11'h001, 11'h003, 11'h004, 11'h00d, 11'h00e};

  dmia_top dut (.clock(clock), .nrst(nrst), .req_valid(req_valid), .req_write(req_write),
    .req_ext(req_ext), .req_addr(req_addr), .req_wdata(req_wdata), .req_bitop(req_bitop),
    .req_bit(req_bit), .rd_valid(rd_valid), .rd_data(rd_data),
    .sfr_look_sector(sfr_look_sector), .sfr_look_offset(sfr_look_offset),
    .sfr_hit(sfr_hit), .sfr_ro(sfr_ro), .sfr_rdata(sfr_rdata), .sfr_we(sfr_we),
    .sfr_sector(sfr_sector), .sfr_offset(sfr_offset), .sfr_wdata(sfr_wdata));
  dmia_sfr_model sfr (.clock(clock), .nrst(nrst), .look_sector(sfr_look_sector),
    .look_offset(sfr_look_offset), .hit(sfr_hit), .ro(sfr_ro), .rdata(sfr_rdata),
    .we(sfr_we), .sector(sfr_sector), .offset(sfr_offset), .wdata(sfr_wdata));

  always #5 clock = ~clock;

  function automatic dmia_row_t rd(logic e, logic [10:0] a, logic [7:0] x);
    rd = '{1'b0, e, a, 8'h00, DMIA_BIT_NONE, 3'h0, x};
  endfunction
  function automatic dmia_row_t wr(logic e, logic [10:0] a, logic [7:0] d);
    wr = '{1'b1, e, a, d, DMIA_BIT_NONE, 3'h0, 8'h00};
  endfunction
  function automatic dmia_row_t bo(logic [10:0] a, dmia_bitop_t op, logic [2:0] b);
    bo = '{1'b0, 1'b1, a, 8'h00, op, b, 8'h00};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One access, held for exactly the edge that takes it
  task automatic acc(input dmia_row_t r);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= r.w;
    req_ext <= r.e;
    req_addr <= r.a;
    req_wdata <= r.d;
    req_bitop <= r.op;
    req_bit <= r.b;
    @(posedge clock);
    req_valid <= 1'b0;
    req_bitop <= DMIA_BIT_NONE;
    #1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_ext = 1'b0;
    req_addr = 11'h000;
    req_wdata = 8'h00;
    req_bitop = DMIA_BIT_NONE;
    req_bit = 3'h0;
    error_cnt = 0;
    cmp_count = 0;
    rows = '{wr(1, 11'h0f0, 8'h11), wr(1, 11'h1f0, 8'h22),
      wr(1, 11'h7ff, 8'h33), rd(1, 11'h1f0, 8'h22),
      wr(0, 11'h003, 8'hf0), wr(0, 11'h004, 8'h01), rd(0, 11'h003, 8'hf0),
      rd(0, 11'h004, 8'h01), rd(0, 11'h002, 8'h22),
      wr(0, 11'h002, 8'h44), rd(1, 11'h1f0, 8'h44),
      wr(0, 11'h001, 8'hf0), rd(0, 11'h000, 8'h11),
      wr(0, 11'h00d, 8'hff), wr(0, 11'h00e, 8'h07), rd(0, 11'h00c, 8'h33),
      wr(0, 11'h00e, 8'h08), wr(0, 11'h00c, 8'h55), rd(0, 11'h00c, 8'h00),
      rd(1, 11'h7ff, 8'h33),
      wr(0, 11'h003, 8'h02), wr(0, 11'h004, 8'h00), rd(0, 11'h002, 8'h00),
      wr(0, 11'h001, 8'h0c), wr(0, 11'h000, 8'h99), rd(0, 11'h000, 8'h00),
      rd(1, 11'h130, 8'h00), rd(1, 11'h17f, 8'h00),
      wr(1, 11'h180, 8'h5e), rd(1, 11'h180, 8'h5e),
      wr(1, 11'h00a, 8'h77), rd(1, 11'h00a, 8'h5a),
      wr(1, 11'h105, 8'h3c), rd(1, 11'h105, 8'h3c),
      bo(11'h0f0, DMIA_BIT_SET, 3'h7), rd(1, 11'h0f0, 8'h91),
      bo(11'h0f0, DMIA_BIT_CLR, 3'h0), rd(1, 11'h0f0, 8'h90)};
    repeat (3) @(posedge clock);
    check({7'h00, rd_valid}, 8'h00);
    check({7'h00, sfr_we}, 8'h00);
    check(rd_data, 8'h00);
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    foreach (ptrs[i]) begin
      acc(rd(0, ptrs[i], 8'h00));
      check(rd_data, 8'h00);
    end
    foreach (rows[i]) begin
      acc(rows[i]);
      if (!rows[i].w && rows[i].op == DMIA_BIT_NONE) begin
        check({7'h00, rd_valid}, 8'h01);
        check(rd_data, rows[i].x);
      end else begin
        check({7'h00, rd_valid}, 8'h00);
      end
    end
    // Pointer written one cycle, used the very next
    acc(wr(1, 11'h280, 8'h6b));
    acc(wr(0, 11'h004, 8'h02));
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_ext <= 1'b0;
    req_addr <= 11'h003;
    req_wdata <= 8'h80;
    acc(rd(0, 11'h002, 8'h00));
    check(rd_data, 8'h6b);
    acc(wr(1, 11'h105, 8'hc7));
    check({7'h00, sfr_we}, 8'h01);
    check({5'h00, sfr_sector}, 8'h01);
    check({1'b0, sfr_offset}, 8'h05);
    check(sfr_wdata, 8'hc7);
    @(posedge clock);
    #1;
    // Strobe stands one cycle only
    check({7'h00, sfr_we}, 8'h00);
    acc(wr(1, 11'h00a, 8'h12));
    check({7'h00, sfr_we}, 8'h00);
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    #1;
    check(rd_data, 8'h00);
    check({7'h00, sfr_we}, 8'h00);
    @(posedge clock);
    nrst <= 1'b1;
    acc(rd(0, 11'h004, 8'h00));
    check(rd_data, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
